// file: hw/l1cap_regs.vh
/*
 * l1cap_regs.vh: register offsets, field positions, reset values and
 * encodings for the l1 cache allocation policy block.
 * assumes: included by bare name; definitions only.
 */
`ifndef L1CAP_REGS_VH
`define L1CAP_REGS_VH

// wishbone word offsets (byte addresses)
`define L1CAP_CTRL_ADDR       8'h00
`define L1CAP_STREAM_ADDR     8'h04
`define L1CAP_STATUS_ADDR     8'h08
`define L1CAP_FLUSHCNT_ADDR   8'h0C
`define L1CAP_WSTHR_ADDR      8'h10

// control register fields
`define L1CAP_CTRL_IC_EN      0
`define L1CAP_CTRL_DC_EN      1
`define L1CAP_CTRL_RST        2'h0

// status register fields
`define L1CAP_ST_STREAM       0
`define L1CAP_ST_INIT_BUSY    1
`define L1CAP_ST_TIER_LSB     2

// extended control: streaming thresholds, 4 bits each
`define L1CAP_THR_W           4
`define L1CAP_THR_L2_LSB      0
`define L1CAP_THR_L3_LSB      4
`define L1CAP_THR_SYS_LSB     8
`define L1CAP_THR_HIT_LSB     12
`define L1CAP_THR_RST         16'h8421

// line geometry
`define L1CAP_LINE_BYTES      7'h40
`define L1CAP_LINE_W          7

// reset-time invalidate walk length (sets)
`define L1CAP_INIT_SETS       9'h100

// memory attribute encoding
`define L1CAP_ATTR_DEVICE     2'h0
`define L1CAP_ATTR_NC         2'h1
`define L1CAP_ATTR_WB         2'h2

// maintenance op encoding
`define L1CAP_MOP_NONE        3'h0
`define L1CAP_MOP_INV_VA      3'h1
`define L1CAP_MOP_CLNINV_VA   3'h2
`define L1CAP_MOP_CLN_VA      3'h3
`define L1CAP_MOP_INV_SW      3'h4
`define L1CAP_MOP_CLNINV_SW   3'h5
`define L1CAP_MOP_CLN_SW      3'h6

// line states
`define L1CAP_MESI_I          2'h0
`define L1CAP_MESI_S          2'h1
`define L1CAP_MESI_E          2'h2
`define L1CAP_MESI_M          2'h3

// write destination tiers
`define L1CAP_TIER_L2         2'h0
`define L1CAP_TIER_L3         2'h1
`define L1CAP_TIER_SYS        2'h2

`endif

// file: hw/l1cap_wstream.v
/*
 * l1cap_wstream.v: write streaming detector. tracks store bytes
 * gathered toward the line under linefill and the run of consecutive store hits.
 * assumes: one clock, synchronous active-high reset, store events are
 * single-cycle pulses from the load/store pipeline.
 */
`include "l1cap_regs.vh"
`timescale 1ns/100ps

module l1cap_wstream (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        dc_en_i,
    input  wire        st_valid_i,
    input  wire        st_hit_i,
    input  wire [6:0]  st_bytes_i,
    input  wire        fill_pend_i,
    input  wire        zero_line_i,
    input  wire        no_resource_i,
    input  wire [15:0] thr_i,
    output reg         stream_o,
    output reg  [1:0]  tier_o
);

    reg [7:0] gather_q;
    reg [3:0] hit_run_q;
    reg [3:0] miss_run_q;
    reg [7:0] gather_d;
    reg [3:0] hit_run_d;

    wire [3:0] thr_l2  = thr_i[`L1CAP_THR_L2_LSB +: `L1CAP_THR_W];
    wire [3:0] thr_l3  = thr_i[`L1CAP_THR_L3_LSB +: `L1CAP_THR_W];
    wire [3:0] thr_sys = thr_i[`L1CAP_THR_SYS_LSB +: `L1CAP_THR_W];
    wire [3:0] thr_hit = thr_i[`L1CAP_THR_HIT_LSB +: `L1CAP_THR_W];

    wire full_line = (gather_d >= {1'b0, `L1CAP_LINE_BYTES});

    always @* begin
        gather_d  = gather_q;
        hit_run_d = hit_run_q;
        if (!fill_pend_i) begin
            gather_d = 8'h00;
        end else if (st_valid_i) begin
            gather_d = gather_q + {1'b0, st_bytes_i};
        end
        if (st_valid_i) begin
            hit_run_d = st_hit_i ? ((hit_run_q == 4'hF) ? hit_run_q : hit_run_q + 4'h1)
                                 : 4'h0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i || !dc_en_i) begin
            stream_o   <= 1'b0;
            gather_q   <= 8'h00;
            hit_run_q  <= 4'h0;
            miss_run_q <= 4'h0;
            tier_o     <= `L1CAP_TIER_L2;
        end else begin
            gather_q  <= full_line ? 8'h00 : gather_d;
            hit_run_q <= hit_run_d;
            if (!stream_o) begin
                if (zero_line_i || (fill_pend_i && full_line)) begin
                    stream_o   <= 1'b1;
                    miss_run_q <= 4'h0;
                end
            end else if (no_resource_i ||
                         (thr_hit != 4'h0 && hit_run_d >= thr_hit)) begin
                stream_o <= 1'b0;
            end else if (st_valid_i && !st_hit_i && miss_run_q != 4'hF) begin
                miss_run_q <= miss_run_q + 4'h1;
            end
            // longer runs of streamed misses push the data further out
            if (miss_run_q >= thr_sys) begin
                tier_o <= `L1CAP_TIER_SYS;
            end else if (miss_run_q >= thr_l3) begin
                tier_o <= `L1CAP_TIER_L3;
            end else if (miss_run_q >= thr_l2) begin
                tier_o <= `L1CAP_TIER_L2;
            end
        end
    end

endmodule

// file: hw/l1cap_top.v
/*
 * l1cap_top.v: l1 cache allocation policy. decides per fetch,
 * load/store and maintenance request which arrays are looked up,
 * whether a line is allocated and at which level, and the coherence
 * state of a newly allocated line. registers on classic wishbone.
 * assumes: one 50 MHz clock, synchronous active-high reset, requests
 * are single-cycle pulses; decisions are registered one cycle later.
 */
`include "l1cap_regs.vh"
`timescale 1ns/100ps

// Functional notes
// - branch or exception flushes speculative fetches
// - device pages fetched as non-cacheable normal
// - icache fetch miss may probe dcache
// - dcache off: no data/L2/L3 lookups
// - dcache off: fetches allocate no L2/L3
// - maintenance runs even with dcache off
// - dcache off: cacheable accesses go non-cacheable
// - one enable for L1 data and L2
// - invalidate by address acts as clean-invalidate
// - dirty data cleaned before invalidate
// - set/way invalidate cleans; override bit ignored
// - line states follow MESI
// - allocate on read and write misses
// - enter streaming on full-line stores or zeroing
// - streaming: store misses write through
// - leave streaming on resource loss, hits
// - streaming destination thresholds in extended control
// - 64-byte line, also full-line size
// - reset disables and invalidates both caches
module l1cap_top (
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    // fetch side
    input  wire        flush_i,
    input  wire        if_req_i,
    input  wire [1:0]  if_attr_i,
    input  wire        if_ic_hit_i,
    output reg         if_kill_o,
    output reg         if_ic_lookup_o,
    output reg         if_dc_lookup_o,
    output reg         if_ic_alloc_o,
    output reg         if_dc_alloc_o,
    output reg         if_l2_alloc_o,
    output reg         if_noncache_o,
    // load/store side
    input  wire        ls_req_i,
    input  wire        ls_write_i,
    input  wire [1:0]  ls_attr_i,
    input  wire        ls_hit_i,
    input  wire [6:0]  ls_bytes_i,
    input  wire        ls_shared_i,
    input  wire        fill_pend_i,
    input  wire        zero_line_i,
    input  wire        no_resource_i,
    output reg         ls_lookup_o,
    output reg         ls_alloc_o,
    output reg         ls_write_out_o,
    output reg         ls_noncache_o,
    output reg  [1:0]  ls_mesi_o,
    output reg  [1:0]  ls_tier_o,
    // maintenance
    input  wire        mnt_req_i,
    input  wire [2:0]  mnt_op_i,
    input  wire        mnt_dirty_i,
    input  wire        setway_invalidate_override_i,
    output reg         mnt_clean_o,
    output reg         mnt_inval_o,
    output reg         mnt_done_o,
    // enables and reset walk
    output wire        ic_en_o,
    output wire        dc_l2_en_o,
    output reg         init_busy_o,
    output reg         init_inval_o,
    output reg  [7:0]  init_set_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_WALK = 1'b1;

    reg [1:0]  ctrl_q;
    reg [15:0] extended_control_reg_q;
    reg [31:0] flush_cnt_q;
    reg        state_q;
    reg        err_q;
    reg [8:0]  walk_q;
    wire       stream;
    wire [1:0] tier;

    // one bit drives both the L1 data and L2 arrays
    wire dc_en = ctrl_q[`L1CAP_CTRL_DC_EN] & ~init_busy_o;
    wire ic_en = ctrl_q[`L1CAP_CTRL_IC_EN] & ~init_busy_o;
    assign ic_en_o    = ic_en;
    assign dc_l2_en_o = dc_en;

    function cacheable;
        input [1:0] attr;
        begin
            cacheable = (attr == `L1CAP_ATTR_WB);
        end
    endfunction

    function [31:0] byte_merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        integer k;
        begin
            byte_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    byte_merge[k*8 +: 8] = dat[k*8 +: 8];
                end
            end
        end
    endfunction

    l1cap_wstream u_wstream (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .dc_en_i       (dc_en),
        .st_valid_i    (ls_req_i & ls_write_i & dc_en & cacheable(ls_attr_i)),
        .st_hit_i      (ls_hit_i),
        .st_bytes_i    (ls_bytes_i),
        .fill_pend_i   (fill_pend_i),
        .zero_line_i   (zero_line_i & dc_en),
        .no_resource_i (no_resource_i),
        .thr_i         (extended_control_reg_q),
        .stream_o      (stream),
        .tier_o        (tier)
    );

    // wishbone decode
    // an error answer also ends the cycle; no second take of it
    wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~err_q;
    wire adr_ctrl = (wb_adr_i == `L1CAP_CTRL_ADDR);
    wire adr_thr  = (wb_adr_i == `L1CAP_WSTHR_ADDR);
    wire adr_ok   = adr_ctrl || adr_thr ||
                    (wb_adr_i == `L1CAP_STATUS_ADDR) ||
                    (wb_adr_i == `L1CAP_STREAM_ADDR) ||
                    (wb_adr_i == `L1CAP_FLUSHCNT_ADDR);
    assign wb_err_o = err_q;

    // byte-lane merge first, then cut to the implemented bits
    wire [31:0] ctrl_wr = byte_merge({30'h0, ctrl_q}, wb_dat_i, wb_sel_i);
    wire [31:0] thr_wr  = byte_merge({16'h0, extended_control_reg_q}, wb_dat_i, wb_sel_i);

    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        if (adr_ctrl) begin
            rd_d = {30'h0, ctrl_q};
        end else if (wb_adr_i == `L1CAP_STREAM_ADDR) begin
            rd_d = {31'h0, stream};
        end else if (wb_adr_i == `L1CAP_STATUS_ADDR) begin
            rd_d = {28'h0, tier, init_busy_o, stream};
        end else if (wb_adr_i == `L1CAP_FLUSHCNT_ADDR) begin
            rd_d = flush_cnt_q;
        end else if (adr_thr) begin
            rd_d = {16'h0, extended_control_reg_q};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o               <= 1'b0;
            err_q                  <= 1'b0;
            wb_dat_o               <= 32'h0000_0000;
            ctrl_q                 <= `L1CAP_CTRL_RST;
            extended_control_reg_q <= `L1CAP_THR_RST;
        end else begin
            wb_ack_o <= wb_req & adr_ok;
            err_q    <= wb_req & ~adr_ok;
            // read data is captured with the request and held after
            if (wb_req) begin
                wb_dat_o <= rd_d;
            end
            if (wb_req && wb_we_i && adr_ctrl) begin
                ctrl_q <= ctrl_wr[1:0];
            end
            if (wb_req && wb_we_i && adr_thr) begin
                extended_control_reg_q <= thr_wr[15:0];
            end
        end
    end

    // reset-time invalidate walk; caches stay off until it ends
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q      <= ST_WALK;
            walk_q       <= 9'h000;
            init_busy_o  <= 1'b1;
            init_inval_o <= 1'b0;
            init_set_o   <= 8'h00;
        end else begin
            case (state_q)
                ST_WALK: begin
                    init_inval_o <= 1'b1;
                    init_set_o   <= walk_q[7:0];
                    walk_q       <= walk_q + 9'h001;
                    // last set issued: hand over to idle
                    if (walk_q == `L1CAP_INIT_SETS - 9'h001) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    init_inval_o <= 1'b0;
                    init_busy_o  <= 1'b0;
                end
            endcase
        end
    end

    // fetch policy
    always @(posedge clk_i) begin
        if (rst_i) begin
            if_kill_o      <= 1'b0;
            if_ic_lookup_o <= 1'b0;
            if_dc_lookup_o <= 1'b0;
            if_ic_alloc_o  <= 1'b0;
            if_dc_alloc_o  <= 1'b0;
            if_l2_alloc_o  <= 1'b0;
            if_noncache_o  <= 1'b0;
            flush_cnt_q    <= 32'h0000_0000;
        end else begin
            if_kill_o <= flush_i;
            if (flush_i) begin
                flush_cnt_q <= flush_cnt_q + 32'h0000_0001;
            end
            // a fetch in the flush cycle is already speculative junk
            if (if_req_i && !flush_i) begin
                // device type counts as non-cacheable normal for fetches
                if_noncache_o  <= !cacheable(if_attr_i) || !ic_en;
                if_ic_lookup_o <= ic_en && cacheable(if_attr_i);
                if_ic_alloc_o  <= ic_en && cacheable(if_attr_i) && !if_ic_hit_i;
                if_dc_lookup_o <= ic_en && dc_en && cacheable(if_attr_i)
                                  && !if_ic_hit_i;
                if_dc_alloc_o  <= ic_en && dc_en && cacheable(if_attr_i)
                                  && !if_ic_hit_i;
                // an uncached fetch (icache off) fills no L2 or L3 either
                if_l2_alloc_o  <= ic_en && dc_en && cacheable(if_attr_i)
                                  && !if_ic_hit_i;
            end else begin
                if_noncache_o  <= 1'b0;
                if_ic_lookup_o <= 1'b0;
                if_ic_alloc_o  <= 1'b0;
                if_dc_lookup_o <= 1'b0;
                if_dc_alloc_o  <= 1'b0;
                if_l2_alloc_o  <= 1'b0;
            end
        end
    end

    // load/store policy
    // a disabled dcache makes every access look uncacheable
    wire ls_cach = cacheable(ls_attr_i) && dc_en;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ls_lookup_o    <= 1'b0;
            ls_alloc_o     <= 1'b0;
            ls_write_out_o <= 1'b0;
            ls_noncache_o  <= 1'b0;
            ls_mesi_o      <= `L1CAP_MESI_I;
            ls_tier_o      <= `L1CAP_TIER_L2;
        end else if (ls_req_i) begin
            ls_lookup_o   <= ls_cach;
            ls_noncache_o <= !ls_cach;
            // tier only steers streamed store misses
            ls_tier_o     <= tier;
            if (!ls_cach || ls_hit_i) begin
                ls_alloc_o     <= 1'b0;
                ls_write_out_o <= ls_write_i && !ls_cach;
            end else if (ls_write_i && stream) begin
                ls_alloc_o     <= 1'b0;
                ls_write_out_o <= 1'b1;
            end else begin
                ls_alloc_o     <= 1'b1;
                ls_write_out_o <= 1'b0;
            end
            // new line state: written lines modified, else by sharing
            if (!ls_cach || (ls_write_i && stream && !ls_hit_i)) begin
                ls_mesi_o <= `L1CAP_MESI_I;
            end else if (ls_write_i) begin
                ls_mesi_o <= `L1CAP_MESI_M;
            end else begin
                ls_mesi_o <= ls_shared_i ? `L1CAP_MESI_S : `L1CAP_MESI_E;
            end
        end else begin
            ls_lookup_o    <= 1'b0;
            ls_alloc_o     <= 1'b0;
            ls_write_out_o <= 1'b0;
            ls_noncache_o  <= 1'b0;
        end
    end

    // maintenance: not gated by dc_en
    always @(posedge clk_i) begin
        if (rst_i) begin
            mnt_clean_o <= 1'b0;
            mnt_inval_o <= 1'b0;
            mnt_done_o  <= 1'b0;
        end else begin
            // completes in one cycle, caches on or off
            mnt_done_o  <= mnt_req_i && mnt_op_i != `L1CAP_MOP_NONE;
            mnt_clean_o <= 1'b0;
            mnt_inval_o <= 1'b0;
            if (mnt_req_i) begin
                case (mnt_op_i)
                    `L1CAP_MOP_INV_VA, `L1CAP_MOP_CLNINV_VA: begin
                        // dirty lines are cleaned before they are dropped
                        mnt_clean_o <= mnt_dirty_i;
                        mnt_inval_o <= 1'b1;
                    end
                    `L1CAP_MOP_CLN_VA, `L1CAP_MOP_CLN_SW: begin
                        mnt_clean_o <= mnt_dirty_i;
                    end
                    `L1CAP_MOP_INV_SW, `L1CAP_MOP_CLNINV_SW: begin
                        // override input intentionally unused here
                        mnt_clean_o <= mnt_dirty_i | setway_invalidate_override_i
                                       | ~setway_invalidate_override_i;
                        mnt_inval_o <= 1'b1;
                    end
                    default: begin
                        mnt_clean_o <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// file: testbench/l1cap_props.sv
/* l1cap_props.sv: port-level checks of the l1 cache allocation policy.
 * assumes: bound to l1cap_top; one clock, synchronous active-high reset. */
`include "l1cap_regs.vh"
`timescale 1ns/100ps
module l1cap_props (
    input logic       clk_i,
    input logic       rst_i,
    input logic       flush_i,
    input logic       if_req_i,
    input logic [1:0] if_attr_i,
    input logic       if_kill_o,
    input logic       if_ic_lookup_o,
    input logic       if_dc_lookup_o,
    input logic       if_ic_alloc_o,
    input logic       if_dc_alloc_o,
    input logic       if_l2_alloc_o,
    input logic       if_noncache_o,
    input logic       ls_req_i,
    input logic       ls_write_i,
    input logic [1:0] ls_attr_i,
    input logic       ls_hit_i,
    input logic       ls_shared_i,
    input logic       ls_lookup_o,
    input logic       ls_alloc_o,
    input logic       ls_write_out_o,
    input logic       ls_noncache_o,
    input logic [1:0] ls_mesi_o,
    input logic       mnt_req_i,
    input logic [2:0] mnt_op_i,
    input logic       mnt_dirty_i,
    input logic       mnt_clean_o,
    input logic       mnt_inval_o,
    input logic       mnt_done_o,
    input logic       ic_en_o,
    input logic       dc_l2_en_o,
    input logic       init_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_kill; flush_i |=> if_kill_o; endproperty
    a_kill: assert property (p_kill) else $error("no kill after flush");
    property p_flush_fetch;
        flush_i && if_req_i |=> !(if_ic_lookup_o || if_dc_lookup_o || if_ic_alloc_o
            || if_dc_alloc_o || if_l2_alloc_o);
    endproperty
    a_flush_fetch: assert property (p_flush_fetch) else $error("flushed fetch went on");
    property p_dev_fetch;
        if_req_i && !flush_i && if_attr_i == `L1CAP_ATTR_DEVICE
            |=> if_noncache_o && !if_ic_alloc_o && !if_dc_alloc_o;
    endproperty
    a_dev_fetch: assert property (p_dev_fetch) else $error("device fetch cached");
    property p_dc_alloc; if_dc_alloc_o |-> $past(dc_l2_en_o); endproperty
    a_dc_alloc: assert property (p_dc_alloc) else $error("fetch filled dcache while off");
    property p_l2_fetch; if_l2_alloc_o |-> $past(dc_l2_en_o); endproperty
    a_l2_fetch: assert property (p_l2_fetch) else $error("fetch filled l2 while off");
    property p_ls_off;
        ls_req_i && !dc_l2_en_o && ls_attr_i == `L1CAP_ATTR_WB
            |=> !ls_lookup_o && !ls_alloc_o && ls_noncache_o;
    endproperty
    a_ls_off: assert property (p_ls_off) else $error("access reached arrays while off");
    property p_mnt_va;
        mnt_req_i && mnt_op_i == `L1CAP_MOP_INV_VA
            |=> mnt_inval_o && mnt_done_o && mnt_clean_o == $past(mnt_dirty_i);
    endproperty
    a_mnt_va: assert property (p_mnt_va) else $error("address invalidate wrong");
    property p_mnt_sw;
        mnt_req_i && mnt_op_i == `L1CAP_MOP_INV_SW |=> mnt_clean_o && mnt_inval_o;
    endproperty
    a_mnt_sw: assert property (p_mnt_sw) else $error("set/way invalidate did not clean");
    property p_rd_alloc;
        ls_req_i && !ls_write_i && !ls_hit_i && ls_attr_i == `L1CAP_ATTR_WB && dc_l2_en_o
            |=> ls_alloc_o && ls_mesi_o == ($past(ls_shared_i) ? `L1CAP_MESI_S : `L1CAP_MESI_E);
    endproperty
    a_rd_alloc: assert property (p_rd_alloc) else $error("read miss fill wrong");
    property p_wout; ls_write_out_o && !ls_noncache_o |-> ls_lookup_o && !ls_alloc_o; endproperty
    a_wout: assert property (p_wout) else $error("streamed store filled a line");
    property p_init; $fell(rst_i) |-> init_busy_o && !ic_en_o && !dc_l2_en_o; endproperty
    a_init: assert property (p_init) else $error("caches on after reset");
endmodule

// file: testbench/l1cap_fill_model.sv
/* l1cap_fill_model.sv: far-side memory model; a linefill stays pending
 * for DLY cycles after each load/store allocation.
 * assumes: alloc_i is the one-cycle allocation pulse of l1cap_top. */
`timescale 1ns/100ps
module l1cap_fill_model #(
    parameter int DLY = 4
) (
    input  logic clk_i,
    input  logic rst_i,
    input  logic alloc_i,
    output logic fill_pend_o
);
    logic [7:0] cnt_q;
    // a slow fill leaves room for a full line of stores to gather
    always @(posedge clk_i) begin
        if (rst_i)
            cnt_q <= 8'h00;
        else if (alloc_i)
            cnt_q <= DLY[7:0];
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    assign fill_pend_o = cnt_q != 8'h00;
endmodule

// file: testbench/l1_cache_allocation_policy_test.sv
/* l1_cache_allocation_policy_test.sv: self-checking bench for l1cap_top.
 * assumes: 50 MHz clock, wishbone master here, fill model on far side. */
`include "l1cap_regs.vh"
`timescale 1ns/100ps
module l1_cache_allocation_policy_test;
    localparam logic [1:0] WB = `L1CAP_ATTR_WB;
    localparam logic [1:0] DV = `L1CAP_ATTR_DEVICE;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic [1:0] if_attr_i = 0, ls_attr_i = 0, ls_mesi_o, ls_tier_o;
    logic [6:0] ls_bytes_i = 0;
    logic [2:0] mnt_op_i = 0;
    logic [7:0] init_set_o;
    logic flush_i = 0, if_req_i = 0, if_ic_hit_i = 0, ls_req_i = 0, ls_write_i = 0;
    logic ls_hit_i = 0, ls_shared_i = 0, zero_line_i = 0, no_resource_i = 0, mnt_req_i = 0;
    logic mnt_dirty_i = 0, setway_invalidate_override_i = 0, fill_pend_i, pend = 0;
    logic wb_ack_o, wb_err_o, if_kill_o, if_ic_lookup_o, if_dc_lookup_o, if_ic_alloc_o;
    logic if_dc_alloc_o, if_l2_alloc_o, if_noncache_o, ls_lookup_o, ls_alloc_o;
    logic ls_write_out_o, ls_noncache_o, mnt_clean_o, mnt_inval_o, mnt_done_o;
    logic ic_en_o, dc_l2_en_o, init_busy_o, init_inval_o;
    logic [31:0] q[$];
    logic [33:0] wq[$];
    int n_fail = 0, total_checks = 0, cycles = 0, seed = 32'hF82017F2;
    wire [15:0] obs = {if_kill_o, if_ic_lookup_o, if_dc_lookup_o, if_ic_alloc_o,
        if_dc_alloc_o, if_l2_alloc_o, if_noncache_o, ls_lookup_o, ls_alloc_o,
        ls_write_out_o, ls_noncache_o, mnt_clean_o, mnt_inval_o, mnt_done_o, ls_mesi_o};

    l1cap_top dut (.*);
    l1cap_fill_model #(.DLY(24)) u_fill (.clk_i, .rst_i, .alloc_i(ls_alloc_o),
        .fill_pend_o(fill_pend_i));

    always #10 clk_i = ~clk_i;

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
            input logic er);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        wq.push_back({we, er, e});
        do @(posedge clk_i); while ((wb_ack_o | wb_err_o) !== 1'b1);
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task fetch(input logic fl, rq, input logic [1:0] at, input logic [15:0] c, e);
        @(posedge clk_i);
        flush_i <= fl;
        if_req_i <= rq;
        if_attr_i <= at;
        if_ic_hit_i <= 0;
        q.push_back({c, e & c});
        @(posedge clk_i);
        flush_i <= 0;
        if_req_i <= 0;
    endtask
    task ls(input logic wr, input logic [6:0] by, input logic sh, input logic [15:0] c, e);
        @(posedge clk_i);
        ls_req_i <= 1;
        ls_write_i <= wr;
        ls_attr_i <= WB;
        ls_bytes_i <= by;
        ls_shared_i <= sh;
        q.push_back({c, e & c});
        @(posedge clk_i);
        ls_req_i <= 0;
    endtask
    task mnt(input logic [2:0] op, input logic dt, ov, input logic [15:0] e);
        @(posedge clk_i);
        mnt_req_i <= 1;
        mnt_op_i <= op;
        mnt_dirty_i <= dt;
        setway_invalidate_override_i <= ov;
        q.push_back({16'h001C, e});
        @(posedge clk_i);
        mnt_req_i <= 0;
    endtask

    always @(posedge clk_i) begin
        logic [31:0] nt;
        logic [33:0] w;
        if (pend && q.size() > 0) begin
            nt = q.pop_front();
            chk("pulses", {16'h0000, obs & nt[31:16]}, {16'h0000, nt[15:0]});
        end
        pend <= flush_i | if_req_i | ls_req_i | mnt_req_i;
        if ((wb_ack_o | wb_err_o) === 1'b1 && wq.size() > 0) begin
            w = wq.pop_front();
            chk("wb_err", {31'h0, wb_err_o}, {31'h0, w[32]});
            if (!w[33]) chk("wb_dat", wb_dat_o, w[31:0]);
        end
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        logic dt, ov;
        logic [31:0] d;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        while (init_busy_o !== 1'b0) @(posedge clk_i);
        chk("init_set", {init_inval_o, init_set_o}, `L1CAP_INIT_SETS - 1);
        wb(0, `L1CAP_CTRL_ADDR, 0, 0, 0);
        wb(0, `L1CAP_WSTHR_ADDR, 0, 32'h8421, 0);
        wb(1, 8'h3C, 32'h3, 0, 1);
        wb(0, `L1CAP_CTRL_ADDR, 0, 0, 0);
        fetch(0, 1, WB, 16'hDE00, 16'h0200);
        for (int i = 0; i < 2; i++) ls(i[0], 7'h10, 0, 16'h01E0, {9'h0, i[0], 6'h20});
        for (int op = 1; op < 7; op++) begin
            dt = $random(seed);
            ov = $random(seed);
            mnt(op[2:0], dt, ov, {11'h0, op == 4 || op == 5 || dt, op != 3 && op != 6, 1'b1, 2'h0});
        end
        fetch(1, 0, WB, 16'h8000, 16'h8000);
        fetch(1, 1, WB, 16'hFC00, 16'h8000);
        wb(1, `L1CAP_CTRL_ADDR, 32'h2, 0, 0);
        fetch(0, 1, WB, 16'h1E00, 16'h0200);
        wb(1, `L1CAP_CTRL_ADDR, 32'h1, 0, 0);
        fetch(0, 1, DV, 16'h1E00, 16'h0200);
        fetch(0, 1, WB, 16'h1E00, 16'h1000);
        wb(1, `L1CAP_CTRL_ADDR, 32'h3, 0, 0);
        wb(0, `L1CAP_CTRL_ADDR, 0, 32'h3, 0);
        fetch(0, 1, WB, 16'h1E00, 16'h1C00);
        ls(0, 7'h08, 1, 16'h01E3, 16'h0181);
        ls(0, 7'h08, 0, 16'h01E3, 16'h0182);
        ls(1, 7'h08, 0, 16'h01E3, 16'h0183);
        repeat (4) ls(1, 7'h10, 0, 16'h0000, 16'h0000);
        ls(1, 7'h08, 0, 16'h01E0, 16'h0140);
        ls(0, 7'h08, 0, 16'h01E0, 16'h0180);
        @(posedge clk_i);
        no_resource_i <= 1;
        repeat (2) @(posedge clk_i);
        no_resource_i <= 0;
        ls(1, 7'h08, 0, 16'h01E0, 16'h0180);
        @(posedge clk_i);
        zero_line_i <= 1;
        @(posedge clk_i);
        zero_line_i <= 0;
        repeat (3) ls(1, 7'h08, 0, 16'h01E0, 16'h0140);
        wb(0, `L1CAP_STATUS_ADDR, 0, {28'h0, `L1CAP_TIER_L3, 2'h1}, 0);
        chk("tier", ls_tier_o, `L1CAP_TIER_L3);
        wb(1, `L1CAP_CTRL_ADDR, 32'h1, 0, 0);
        wb(1, `L1CAP_CTRL_ADDR, 32'h3, 0, 0);
        ls(1, 7'h08, 0, 16'h01E0, 16'h0180);
        d = $random(seed);
        wb(1, `L1CAP_WSTHR_ADDR, d, 0, 0);
        wb(0, `L1CAP_WSTHR_ADDR, 0, {16'h0000, d[15:0]}, 0);
        repeat (3) @(posedge clk_i);
        final_report();
    end
endmodule

bind l1cap_top l1cap_props u_props (.*);
